// [hw/pic_defs.svh]
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_EDGE      8'h04
`define OFS_MASK      8'h08
`define OFS_PEND      8'h0C
`define OFS_SERVICE   8'h10
`define OFS_LPBASE    8'h14
`define OFS_IRQSTAT   8'h18
`define OFS_IRQCLR    8'h1C
`define OFS_IRQEN     8'h20

// reset values
`define RST_CTRL      1'h0
`define RST_EDGE      6'h00
`define RST_MASK      16'h0000
`define RST_LPBASE    16'h0000
`define RST_IRQEN     3'h0

// field positions
`define CTRL_GLOBAL_EN 0
`define EV_SERVICE    0
`define EV_POWERDOWN  1
`define EV_FAULT      2

// pending levels
`define LVL_POWER     0
`define LVL_FAULT     1
`define LVL_IO_FIRST  12
`define LVL_IO_SECOND 14
`define USER_LVL_BITS 16'hAD04
`define MACHINE_LVL_BITS 16'h02FA

// synchronised pin vector positions
`define PIN_POWER     0
`define PIN_USER_LO   1
`define PIN_IO_LO     7
`define PIN_FAULT     9
`define PIN_COUNT     10

// acknowledge strobe width
`define CLK_PERIOD_NS 40
`define ACK_TIME_NS   80
`define ACK_CYCLES    ((`ACK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [hw/pic_pkg.sv]
package pic_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACK  = 2'b10
   } svc_state_t;
   typedef logic [15:0] level_vec_t;
endpackage

// [hw/pin_sync.sv]
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 10
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // pins
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinSync
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // idle level of active-low pins is high
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1_reg <= '1;
         stage2_reg <= '1;
      end else begin
         stage1_reg <= pinIn;
         stage2_reg <= stage1_reg;
      end
   end

   assign pinSync = stage2_reg;
endmodule

// [hw/priority_pick.sv]
`timescale 1ns/10ps
module priority_pick (
   // candidates
   input wire logic [15:0] eligible,
   // result
   output logic found,
   output logic [3:0] level
);
   // lowest index wins
   function automatic logic [3:0] firstSet(input logic [15:0] v);
      logic [3:0] r;
      r = 4'hF;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   assign found = |eligible;
   assign level = firstSet(eligible);
endmodule

// [hw/pending_interrupt_capture.sv]
// Overview of operation
// - low power-down request sets pending level 0.
// - level 0 beats all levels and ignores mask and disable.
// - six user request pins set levels 2, 8, 10, 11, 13, 15.
// - among user levels, lower number means higher priority.
// - user levels each maskable and gated by global disable.
// - edge mode captures user request on its high-to-low transition.
// - level mode samples user request at machine cycle end.
// - levels 3-7, 9 come only from internal machine sources; level 1 also from the bus fault pin.
// - first I/O pin sets level 12, second sets level 14.
// - I/O pins are level only, sampled at machine cycle end.
// - levels 12 and 14 maskable and gated by global disable.
// - acknowledge strobe goes low to start interrupt service.
// - while strobe low, linkage pointer address is on address bus.
// - bus fault sets pending level 1.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "pic_defs.svh"
module pending_interrupt_capture
   import pic_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt pins
   input wire logic power_down_request_n,
   input wire logic user_irq_lvl2_n,
   input wire logic user_irq_lvl8_n,
   input wire logic user_irq_lvl10_n,
   input wire logic user_irq_lvl11_n,
   input wire logic user_irq_lvl13_n,
   input wire logic user_irq_lvl15_n,
   input wire logic io_irq_first_n,
   input wire logic io_irq_second_n,
   input wire logic busFault_n,
   // state sequencer
   input wire logic machineCycleEnd,
   input wire logic serviceReq,
   input wire logic [15:0] machineIrq,
   output logic serviceTaken,
   output logic [3:0] serviceLevel,
   // acknowledge and address bus
   output logic irq_ack_strobe_n,
   output logic [15:0] addrOut,
   output logic addrOe_n,
   // interrupt
   output logic irq
);
   logic [`PIN_COUNT-1:0] pinRaw;
   logic [`PIN_COUNT-1:0] pinS;
   logic [5:0] userPrev_reg;
   level_vec_t pending_interrupt_reg;
   level_vec_t pendNext;
   logic globalEn_reg;
   logic [5:0] edgeSel_reg;
   level_vec_t mask_reg;
   logic [15:0] lpBase_reg;
   logic [2:0] irqStat_reg;
   logic [2:0] irqEn_reg;
   logic [31:0] prdata_reg;
   svc_state_t state_reg;
   svc_state_t stateNext;
   logic [3:0] ackCnt_reg;
   logic [3:0] level_reg;
   logic [15:0] addr_reg;
   logic taken_reg;

   assign pinRaw = {busFault_n, io_irq_second_n, io_irq_first_n, user_irq_lvl15_n, user_irq_lvl13_n,
                    user_irq_lvl11_n, user_irq_lvl10_n, user_irq_lvl8_n, user_irq_lvl2_n, power_down_request_n};

   pin_sync #(.WIDTH(`PIN_COUNT)) u_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pinIn(pinRaw),
      .pinSync(pinS)
   );

   // user pins mapped to their levels, in order 2, 8, 10, 11, 13, 15
   function automatic level_vec_t userMap(input logic [5:0] u);
      level_vec_t v;
      v = '0;
      v[2] = u[0];
      v[8] = u[1];
      v[10] = u[2];
      v[11] = u[3];
      v[13] = u[4];
      v[15] = u[5];
      return v;
   endfunction

   function automatic logic [15:0] lpAddr(input logic [15:0] base, input logic [3:0] lvl);
      return base + {11'h000, lvl, 1'b0};
   endfunction

   // capture
   wire logic [5:0] userS = pinS[`PIN_USER_LO +: 6];
   wire logic [1:0] ioS = pinS[`PIN_IO_LO +: 2];
   wire logic [5:0] userFall = userPrev_reg & ~userS;
   wire logic [5:0] userLevelCap = {6{machineCycleEnd}} & ~userS;
   wire logic [5:0] userCap = (edgeSel_reg & userFall) | (~edgeSel_reg & userLevelCap);
   wire logic [1:0] ioCap = {2{machineCycleEnd}} & ~ioS;
   wire logic faultCap = ~pinS[`PIN_FAULT];
   wire logic powerCap = ~pinS[`PIN_POWER];
   wire level_vec_t machineSet = machineIrq & `MACHINE_LVL_BITS;
   wire level_vec_t setVec = machineSet | userMap(userCap)
                           | (level_vec_t'(ioCap[0]) << `LVL_IO_FIRST)
                           | (level_vec_t'(ioCap[1]) << `LVL_IO_SECOND)
                           | (level_vec_t'(faultCap) << `LVL_FAULT)
                           | level_vec_t'(powerCap);

   // eligibility and selection
   wire level_vec_t gateVec = {16{globalEn_reg}} & mask_reg;
   wire level_vec_t eligible = pending_interrupt_reg & (gateVec | level_vec_t'(1'b1));
   wire logic pickFound;
   wire logic [3:0] pickLevel;

   priority_pick u_pick (
      .eligible(eligible),
      .found(pickFound),
      .level(pickLevel)
   );

   wire logic startSvc = (state_reg == ST_IDLE) && serviceReq && pickFound;
   wire level_vec_t svcClr = startSvc ? (level_vec_t'(1'b1) << pickLevel) : '0;
   assign pendNext = (pending_interrupt_reg & ~svcClr) | setVec;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pending_interrupt_reg <= '0;
         userPrev_reg <= '1;
      end else begin
         pending_interrupt_reg <= pendNext;
         userPrev_reg <= userS;
      end
   end

   // service sequence
   wire logic ackDone = (ackCnt_reg == 4'(`ACK_CYCLES - 1));
   always_comb begin
      stateNext = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (startSvc) begin
               stateNext = ST_ACK;
            end
         end
         ST_ACK: begin
            if (ackDone) begin
               stateNext = ST_IDLE;
            end
         end
         default: begin
            stateNext = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         ackCnt_reg <= 4'h0;
         level_reg <= 4'h0;
         addr_reg <= 16'h0000;
         taken_reg <= 1'b0;
      end else begin
         state_reg <= stateNext;
         ackCnt_reg <= (state_reg == ST_ACK) ? ackCnt_reg + 4'h1 : 4'h0;
         taken_reg <= startSvc;
         if (startSvc) begin
            level_reg <= pickLevel;
            addr_reg <= lpAddr(lpBase_reg, pickLevel);
         end
      end
   end

   assign irq_ack_strobe_n = (state_reg != ST_ACK);
   assign addrOe_n = irq_ack_strobe_n;
   assign addrOut = addr_reg;
   assign serviceLevel = level_reg;
   assign serviceTaken = taken_reg;

   // apb decode
   wire logic setup = psel && !penable;
   wire logic wrAcc = psel && penable && pwrite;
   wire logic selCtrl = (paddr == `OFS_CTRL);
   wire logic selEdge = (paddr == `OFS_EDGE);
   wire logic selMask = (paddr == `OFS_MASK);
   wire logic selPend = (paddr == `OFS_PEND);
   wire logic selSvc = (paddr == `OFS_SERVICE);
   wire logic selLp = (paddr == `OFS_LPBASE);
   wire logic selStat = (paddr == `OFS_IRQSTAT);
   wire logic selClr = (paddr == `OFS_IRQCLR);
   wire logic selEn = (paddr == `OFS_IRQEN);
   wire logic mapped = selCtrl | selEdge | selMask | selPend | selSvc | selLp | selStat | selClr | selEn;
   wire logic [31:0] rdMux = selCtrl ? {31'h0, globalEn_reg} :
                             selEdge ? {26'h0, edgeSel_reg} :
                             selMask ? {16'h0, mask_reg} :
                             selPend ? {16'h0, pending_interrupt_reg} :
                             selSvc ? {27'h0, ~irq_ack_strobe_n, level_reg} :
                             selLp ? {16'h0, lpBase_reg} :
                             selStat ? {29'h0, irqStat_reg} :
                             selEn ? {29'h0, irqEn_reg} : 32'h0000_0000;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         globalEn_reg <= `RST_CTRL;
         edgeSel_reg <= `RST_EDGE;
         mask_reg <= `RST_MASK;
         lpBase_reg <= `RST_LPBASE;
         irqEn_reg <= `RST_IRQEN;
         prdata_reg <= 32'h0000_0000;
      end else begin
         if (setup) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : rdMux;
         end
         if (wrAcc && selCtrl) begin
            globalEn_reg <= pwdata[`CTRL_GLOBAL_EN];
         end
         if (wrAcc && selEdge) begin
            edgeSel_reg <= pwdata[5:0];
         end
         if (wrAcc && selMask) begin
            mask_reg <= pwdata[15:0];
         end
         if (wrAcc && selLp) begin
            lpBase_reg <= pwdata[15:0];
         end
         if (wrAcc && selEn) begin
            irqEn_reg <= pwdata[2:0];
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // event status: set wins over clear
   wire logic [2:0] evSet = {faultCap, powerCap, startSvc};
   wire logic [2:0] evClr = (wrAcc && selClr) ? pwdata[2:0] : 3'h0;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irqStat_reg <= 3'h0;
      end else begin
         irqStat_reg <= (irqStat_reg & ~evClr) | evSet;
      end
   end

   assign irq = |(irqStat_reg & irqEn_reg);

   // checks
   power_capture_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !pinS[`PIN_POWER] |=> pending_interrupt_reg[`LVL_POWER]) else $error("power-down not captured");
   level0_first_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (startSvc && pending_interrupt_reg[0]) |=> (level_reg == 4'h0)) else $error("level 0 not served first");
   user_map_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (machineCycleEnd && !edgeSel_reg[1] && !userS[1]) |=> pending_interrupt_reg[8]) else $error("level 8 missed");
   priority_order_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      startSvc |-> ((eligible & ((16'h0001 << pickLevel) - 16'h0001)) == 16'h0000)) else $error("wrong priority");
   mask_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      startSvc |-> (pickLevel == 4'h0 || (globalEn_reg && mask_reg[pickLevel]))) else $error("masked level served");
   edge_capture_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (edgeSel_reg[2] && $fell(userS[2])) |=> pending_interrupt_reg[10]) else $error("edge not captured");
   reserved_src_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(pending_interrupt_reg[5]) |-> $past(machineIrq[5])) else $error("reserved level set by pin");
   io_level_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (machineCycleEnd && !ioS[1]) |=> pending_interrupt_reg[`LVL_IO_SECOND]) else $error("level 14 missed");
   lp_on_bus_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      startSvc |=> (!irq_ack_strobe_n && !addrOe_n && addrOut == lpAddr(lpBase_reg, level_reg)))
      else $error("linkage pointer not driven");
   ack_width_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $fell(irq_ack_strobe_n) |-> !irq_ack_strobe_n [*2] ##1 irq_ack_strobe_n) else $error("ack width wrong");
   fault_level_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      faultCap |=> pending_interrupt_reg[`LVL_FAULT]) else $error("fault level not set");
   pend_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      1'b1 |=> ((($past(pending_interrupt_reg) & ~$past(svcClr)) & ~pending_interrupt_reg) == 16'h0000))
      else $error("pending bit lost");

   power_svc_c: cover property (@(posedge core_clk) disable iff (!rst_b) startSvc && pickLevel == 4'h0);
   user_svc_c: cover property (@(posedge core_clk) disable iff (!rst_b) startSvc && pickLevel == 4'hF);
   io_svc_c: cover property (@(posedge core_clk) disable iff (!rst_b) startSvc && pickLevel == 4'hC);
   irq_out_c: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(irq));
endmodule

// [testbench/irq_source_model.sv]
`timescale 1ns/10ps
module irq_source_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // bench control
   input wire logic [7:0] raiseReq,
   input wire logic [15:0] lpBase,
   // device side
   input wire logic irq_ack_strobe_n,
   input wire logic [15:0] addrOut,
   // request pins, idle high
   output logic [7:0] reqPinsN,
   output logic [3:0] seenLevel
);
   localparam logic [3:0] PIN_LVL [8] = '{4'h2, 4'h8, 4'hA, 4'hB, 4'hD, 4'hF, 4'hC, 4'hE};
   wire logic [15:0] offset = addrOut - lpBase;
   wire logic [3:0] ackLevel = offset[4:1];
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reqPinsN <= 8'hFF;
         seenLevel <= 4'h0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (raiseReq[i])
               reqPinsN[i] <= 1'b0;
            else if (!irq_ack_strobe_n && ackLevel == PIN_LVL[i])
               reqPinsN[i] <= 1'b1;
         end
         if (!irq_ack_strobe_n)
            seenLevel <= ackLevel;
      end
   end
endmodule

// [testbench/pending_interrupt_capture_tb_top.sv]
`timescale 1ns/10ps
`include "pic_defs.svh"
module pending_interrupt_capture_tb_top;
   typedef struct {int pin; logic [3:0] lvl;} row_t;
   logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic powerDownN = 1'b1, faultN = 1'b1, mce = 1'b0, serviceReq = 1'b0;
   logic [7:0] paddr = 8'h00, raiseReq = 8'h00, reqPinsN;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [15:0] machineIrq = 16'h0000, addrOut, lpBase = 16'h4000;
   logic pready, pslverr, serviceTaken, ackN, addrOeN, irq, e;
   logic [3:0] serviceLevel, seenLevel;
   int errCount = 0, samplesChecked = 0;
   row_t rows [8] = '{'{0, 4'h2}, '{1, 4'h8}, '{2, 4'hA}, '{3, 4'hB}, '{4, 4'hD}, '{5, 4'hF},
                      '{6, 4'hC}, '{7, 4'hE}};
   logic [3:0] order [7] = '{4'h2, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
   logic [7:0] regOfs [7] = '{`OFS_CTRL, `OFS_EDGE, `OFS_MASK, `OFS_PEND, `OFS_LPBASE, `OFS_IRQSTAT, `OFS_IRQEN};

   initial begin
      forever #20 core_clk = ~core_clk;
   end

   pending_interrupt_capture dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_down_request_n(powerDownN), .user_irq_lvl2_n(reqPinsN[0]), .user_irq_lvl8_n(reqPinsN[1]),
      .user_irq_lvl10_n(reqPinsN[2]), .user_irq_lvl11_n(reqPinsN[3]), .user_irq_lvl13_n(reqPinsN[4]),
      .user_irq_lvl15_n(reqPinsN[5]), .io_irq_first_n(reqPinsN[6]), .io_irq_second_n(reqPinsN[7]),
      .busFault_n(faultN), .machineCycleEnd(mce), .serviceReq(serviceReq), .machineIrq(machineIrq),
      .serviceTaken(serviceTaken), .serviceLevel(serviceLevel), .irq_ack_strobe_n(ackN),
      .addrOut(addrOut), .addrOe_n(addrOeN), .irq(irq));

   irq_source_model partner (.core_clk(core_clk), .rst_b(rst_b), .raiseReq(raiseReq), .lpBase(lpBase),
      .irq_ack_strobe_n(ackN), .addrOut(addrOut), .reqPinsN(reqPinsN), .seenLevel(seenLevel));

   task automatic printVerdict();
      $display("checks %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samplesChecked++;
      if (seen !== exp) begin
         errCount++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic stall();
      errCount++;
      $display("MISMATCH t=%0t wait ran out", $time);
      printVerdict();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         stall();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, q, e);
      check(q, exp, "register read");
   endtask

   task automatic raise(input logic [7:0] m);
      raiseReq <= m;
      @(posedge core_clk);
      raiseReq <= 8'h00;
   endtask

   task automatic pulseMce();
      mce <= 1'b1;
      @(posedge core_clk);
      mce <= 1'b0;
      cyc(3);
   endtask

   task automatic serve(input logic [3:0] lvl);
      int n;
      n = 0;
      serviceReq <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (ackN !== 1'b0 && n < 20);
      if (n >= 20)
         stall();
      serviceReq <= 1'b0;
      check(serviceTaken, 1'b1, "taken pulse");
      check(addrOut, lpBase + {lvl, 1'b0}, "linkage address");
      check(addrOeN, 1'b0, "address drive");
      check(serviceLevel, lvl, "served level");
      @(posedge core_clk);
      check({ackN, serviceTaken}, 2'b00, "second strobe cycle");
      @(posedge core_clk);
      check(ackN, 1'b1, "strobe released");
      check(seenLevel, lvl, "level seen on bus");
   endtask

   task automatic noServe();
      serviceReq <= 1'b1;
      repeat (6) begin
         @(posedge core_clk);
         check(ackN, 1'b1, "no service");
      end
      serviceReq <= 1'b0;
   endtask

   initial begin
      cyc(12);
      rst_b <= 1'b1;
      wr(`OFS_LPBASE, 32'h4000);
      wr(`OFS_CTRL, 32'h1);
      wr(`OFS_MASK, 32'hFFFF);
      foreach (rows[i]) begin
         raise(8'h01 << rows[i].pin);
         mce <= 1'b1;
         cyc(5);
         mce <= 1'b0;
         cyc(2);
         rdChk(`OFS_PEND, 32'h1 << rows[i].lvl);
         serve(rows[i].lvl);
         rdChk(`OFS_PEND, 32'h0);
      end
      $display("test pin table done");
      raise(8'h01);
      cyc(6);
      rdChk(`OFS_PEND, 32'h0);
      pulseMce();
      rdChk(`OFS_PEND, 32'h4);
      raise(8'hFE);
      cyc(4);
      pulseMce();
      rdChk(`OFS_PEND, 32'hFD04);
      wr(`OFS_MASK, 32'hFEFF);
      foreach (order[i]) serve(order[i]);
      rdChk(`OFS_PEND, 32'h0100);
      wr(`OFS_MASK, 32'hFFFF);
      wr(`OFS_CTRL, 32'h0);
      noServe();
      powerDownN <= 1'b0;
      cyc(4);
      powerDownN <= 1'b1;
      cyc(3);
      rdChk(`OFS_PEND, 32'h0101);
      serve(4'h0);
      noServe();
      wr(`OFS_CTRL, 32'h1);
      serve(4'h8);
      $display("test priority done");
      wr(`OFS_EDGE, 32'h3F);
      raise(8'h44);
      cyc(6);
      rdChk(`OFS_PEND, 32'h0400);
      pulseMce();
      rdChk(`OFS_PEND, 32'h1400);
      serve(4'hA);
      serve(4'hC);
      wr(`OFS_EDGE, 32'h0);
      $display("test edge done");
      wr(`OFS_IRQEN, 32'h7);
      faultN <= 1'b0;
      cyc(4);
      faultN <= 1'b1;
      cyc(3);
      rdChk(`OFS_PEND, 32'h0002);
      rdChk(`OFS_IRQSTAT, 32'h7);
      check(irq, 1'b1, "irq raised");
      wr(`OFS_IRQCLR, 32'h7);
      rdChk(`OFS_IRQSTAT, 32'h0);
      check(irq, 1'b0, "irq cleared");
      serve(4'h1);
      wr(`OFS_IRQEN, 32'h6);
      rdChk(`OFS_IRQSTAT, 32'h1);
      check(irq, 1'b0, "irq masked");
      wr(`OFS_IRQEN, 32'h1);
      cyc(1);
      check(irq, 1'b1, "irq enabled");
      machineIrq <= 16'hFFFF;
      cyc(1);
      machineIrq <= 16'h0000;
      rdChk(`OFS_PEND, 32'h02FA);
      apb(1'b0, 8'h40, 32'h0, q, e);
      check(e, 1'b1, "unmapped error");
      check(q, 32'h0, "unmapped read data");
      $display("test interrupt done");
      raise(8'h01);
      mce <= 1'b1;
      cyc(5);
      rst_b <= 1'b0;
      mce <= 1'b0;
      cyc(3);
      check({ackN, addrOeN, irq}, 3'b110, "outputs in reset");
      check({serviceTaken, serviceLevel, addrOut}, 21'h0, "sequencer in reset");
      rst_b <= 1'b1;
      foreach (regOfs[i]) rdChk(regOfs[i], 32'h0);
      $display("test reset done");
      printVerdict();
   end
endmodule
